// ### src/p6cpm_regs.svh
// Purpose: Register offsets, field positions and reset values for port 6
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Included by the port 6 design file only
`ifndef P6CPM_REGS_SVH
`define P6CPM_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define P6_OFF_LATCH     12'h000
`define P6_OFF_DIR       12'h004
`define P6_OFF_MODE      12'h008
`define P6_OFF_WAITLO    12'h00c
`define P6_OFF_WAITHI    12'h010
`define P6_OFF_HOLD      12'h014
`define P6_OFF_REFRESH   12'h018
`define P6_OFF_PULLUP    12'h01c
`define P6_OFF_STATUS    12'h020

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define P6_HOLD_EN_BIT   0
`define P6_REFR_EN_BIT   0
`define P6_PULLUP_BIT    6
`define P6_DIR_RESET     8'hff
`define P6_LATCH_RESET   8'h00
`define P6_WAIT_EXT      2'h3

// Pin positions
`define P6_PIN_RD        4
`define P6_PIN_WR        5
`define P6_PIN_WAIT      6
`define P6_PIN_ACK       7

`endif

// ### src/p6cpm_pkg.sv
// Purpose: Types for the port 6 control pin multiplexer
// Assumes: Nothing beyond the register header
// Notes:   Expansion mode codes as a typed enum
package p6cpm_pkg;

  typedef enum logic [3:0] {
    P6CPM_MM_PORT   = 4'h0,
    P6CPM_MM_PORT3  = 4'h3,
    P6CPM_MM_RW4    = 4'h4,
    P6CPM_MM_RW5    = 4'h5,
    P6CPM_MM_RW6    = 4'h6,
    P6CPM_MM_RW7    = 4'h7,
    P6CPM_MM_A17    = 4'h8,
    P6CPM_MM_A19    = 4'h9
  } p6cpm_mode_t;

endpackage

// ### src/p6cpm_port6.sv
// Purpose: Port 6, eight I/O pins with external bus control functions
// Assumes: APB slave at 40 MHz, async active-high reset
// Notes:   Peripheral functions come in as signals and own their pins
`timescale 1ns/10ps
`include "p6cpm_regs.svh"

module p6cpm_port6 #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        upperAddr,
  input  wire logic              extAccess,
  input  wire logic              readStrobeN,
  input  wire logic              writeStrobeN,
  input  wire logic              holdAckN,
  input  wire logic              refreshReqN,
  input  wire logic [7:0]        pinIn,
  output logic      [7:0]        pinOut,
  output logic      [7:0]        pinOe,
  output logic      [7:0]        pullupEn,
  output logic                   waitIn,
  output logic                   holdReqIn,
  output logic                   extWaitSel,
  output logic                   holdEnable
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [7:0]  latch_r, latch_nxt;
  logic [7:0]  dir_r, dir_nxt;
  logic [3:0]  mode_r, mode_nxt;
  logic [15:0] waitLo_r, waitLo_nxt;
  logic [15:0] waitHi_r, waitHi_nxt;
  logic        holdEn_r, holdEn_nxt;
  logic        refrEn_r, refrEn_nxt;
  logic        pullOpt_r, pullOpt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;

  // Pin synchroniser and output stage
  logic [7:0]  pinSync1_r, pinSync2_r;
  logic [7:0]  pinOut_r, pinOut_nxt;
  logic [7:0]  pinOe_r, pinOe_nxt;
  logic [7:0]  pullup_r, pullup_nxt;
  logic        waitIn_r, waitIn_nxt;
  logic        holdReq_r, holdReq_nxt;
  logic        extWait_r, extWait_nxt;

  logic [7:0]  ctrlMask;
  logic [7:0]  ctrlOut;
  logic [7:0]  ctrlOe;
  logic        accAddr;
  logic        accRw;
  logic        anyExtWait;

  p6cpm_pkg::p6cpm_mode_t modeCode;

  // --------------------------------------------------------------------
  // Pin function decode
  // --------------------------------------------------------------------
  always_comb begin
    modeCode   = p6cpm_pkg::p6cpm_mode_t'(mode_r);
    ctrlMask   = 8'h00;
    ctrlOut    = 8'h00;
    ctrlOe     = 8'h00;
    accAddr    = 1'b0;
    accRw      = 1'b0;
    anyExtWait = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (waitLo_r[2*i +: 2] == `P6_WAIT_EXT) begin
        anyExtWait = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (waitHi_r[2*i +: 2] == `P6_WAIT_EXT) begin
        anyExtWait = 1'b1;
      end
    end
    unique case (modeCode)
      p6cpm_pkg::P6CPM_MM_RW4, p6cpm_pkg::P6CPM_MM_RW5,
      p6cpm_pkg::P6CPM_MM_RW6, p6cpm_pkg::P6CPM_MM_RW7: begin
        accRw = 1'b1;
      end
      p6cpm_pkg::P6CPM_MM_A17: begin
        accRw = 1'b1;
        ctrlMask[1:0] = 2'h3;
      end
      p6cpm_pkg::P6CPM_MM_A19: begin
        accRw = 1'b1;
        ctrlMask[3:0] = 4'hf;
      end
      default: begin
        accRw = 1'b0;
      end
    endcase
    // Address lines idle low outside expanded space accesses
    accAddr = extAccess;
    for (int i = 0; i < 4; i++) begin
      ctrlOut[i] = accAddr & upperAddr[i];
      ctrlOe[i]  = ctrlMask[i];
    end
    if (accRw) begin
      ctrlMask[`P6_PIN_RD] = 1'b1;
      ctrlMask[`P6_PIN_WR] = 1'b1;
      ctrlOut[`P6_PIN_RD]  = readStrobeN;
      ctrlOut[`P6_PIN_WR]  = writeStrobeN;
      ctrlOe[`P6_PIN_RD]   = 1'b1;
      ctrlOe[`P6_PIN_WR]   = 1'b1;
    end
    if (holdEn_r) begin
      ctrlMask[`P6_PIN_WAIT] = 1'b1;
      ctrlMask[`P6_PIN_ACK]  = 1'b1;
      ctrlOut[`P6_PIN_ACK]   = holdAckN;
      ctrlOe[`P6_PIN_ACK]    = 1'b1;
    end else if (refrEn_r) begin
      ctrlMask[`P6_PIN_ACK] = 1'b1;
      ctrlOut[`P6_PIN_ACK]  = refreshReqN;
      ctrlOe[`P6_PIN_ACK]   = 1'b1;
    end
    if (anyExtWait) begin
      ctrlMask[`P6_PIN_WAIT] = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Pin drive, pull-ups and sampled control inputs
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ctrlMask[i]) begin
        pinOut_nxt[i] = ctrlOut[i];
        pinOe_nxt[i]  = ctrlOe[i];
        pullup_nxt[i] = 1'b0;
      end else begin
        pinOut_nxt[i] = latch_r[i];
        pinOe_nxt[i]  = ~dir_r[i];
        pullup_nxt[i] = pullOpt_r & dir_r[i];
      end
    end
    // Wait pin also serves when left as a plain input
    waitIn_nxt  = (anyExtWait | dir_r[`P6_PIN_WAIT]) & ~holdEn_r
                & pinSync2_r[`P6_PIN_WAIT];
    holdReq_nxt = holdEn_r & pinSync2_r[`P6_PIN_WAIT];
    extWait_nxt = anyExtWait;
  end

  // --------------------------------------------------------------------
  // APB register access
  // --------------------------------------------------------------------
  always_comb begin
    latch_nxt   = latch_r;
    dir_nxt     = dir_r;
    mode_nxt    = mode_r;
    waitLo_nxt  = waitLo_r;
    waitHi_nxt  = waitHi_r;
    holdEn_nxt  = holdEn_r;
    refrEn_nxt  = refrEn_r;
    pullOpt_nxt = pullOpt_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    // No wait state: answer in the first access phase cycle after setup
    pready_nxt  = psel & ~penable;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `P6_OFF_LATCH: begin
          if (pwrite) begin
            // Whole byte always written; bit ops arrive as byte RMW
            latch_nxt = pwdata[7:0];
          end else begin
            for (int i = 0; i < 8; i++) begin
              if (ctrlMask[i]) begin
                prdata_nxt[i] = 1'b0;
              end else if (dir_r[i]) begin
                prdata_nxt[i] = pinSync2_r[i];
              end else begin
                prdata_nxt[i] = latch_r[i];
              end
            end
          end
        end
        `P6_OFF_DIR: begin
          if (pwrite) dir_nxt = pwdata[7:0];
          else prdata_nxt[7:0] = dir_r;
        end
        `P6_OFF_MODE: begin
          if (pwrite) mode_nxt = pwdata[3:0];
          else prdata_nxt[3:0] = mode_r;
        end
        `P6_OFF_WAITLO: begin
          if (pwrite) waitLo_nxt = pwdata[15:0];
          else prdata_nxt[15:0] = waitLo_r;
        end
        `P6_OFF_WAITHI: begin
          if (pwrite) waitHi_nxt = pwdata[15:0];
          else prdata_nxt[15:0] = waitHi_r;
        end
        `P6_OFF_HOLD: begin
          if (pwrite) holdEn_nxt = pwdata[`P6_HOLD_EN_BIT];
          else prdata_nxt[`P6_HOLD_EN_BIT] = holdEn_r;
        end
        `P6_OFF_REFRESH: begin
          if (pwrite) refrEn_nxt = pwdata[`P6_REFR_EN_BIT];
          else prdata_nxt[`P6_REFR_EN_BIT] = refrEn_r;
        end
        `P6_OFF_PULLUP: begin
          if (pwrite) pullOpt_nxt = pwdata[`P6_PULLUP_BIT];
          else prdata_nxt[`P6_PULLUP_BIT] = pullOpt_r;
        end
        `P6_OFF_STATUS: begin
          if (!pwrite) begin
            prdata_nxt[7:0]  = ctrlMask;
            prdata_nxt[15:8] = pinOe_r;
          end
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r    <= `P6_LATCH_RESET;
      dir_r      <= `P6_DIR_RESET;
      mode_r     <= 4'h0;
      waitLo_r   <= 16'h0000;
      waitHi_r   <= 16'h0000;
      holdEn_r   <= 1'b0;
      refrEn_r   <= 1'b0;
      pullOpt_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      pinSync1_r <= 8'h00;
      pinSync2_r <= 8'h00;
      pinOut_r   <= 8'h00;
      pinOe_r    <= 8'h00;
      pullup_r   <= 8'h00;
      waitIn_r   <= 1'b0;
      holdReq_r  <= 1'b0;
      extWait_r  <= 1'b0;
    end else begin
      latch_r    <= latch_nxt;
      dir_r      <= dir_nxt;
      mode_r     <= mode_nxt;
      waitLo_r   <= waitLo_nxt;
      waitHi_r   <= waitHi_nxt;
      holdEn_r   <= holdEn_nxt;
      refrEn_r   <= refrEn_nxt;
      pullOpt_r  <= pullOpt_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      pinSync1_r <= pinIn;
      pinSync2_r <= pinSync1_r;
      pinOut_r   <= pinOut_nxt;
      pinOe_r    <= pinOe_nxt;
      pullup_r   <= pullup_nxt;
      waitIn_r   <= waitIn_nxt;
      holdReq_r  <= holdReq_nxt;
      extWait_r  <= extWait_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign pinOut     = pinOut_r;
  assign pinOe      = pinOe_r;
  assign pullupEn   = pullup_r;
  assign waitIn     = waitIn_r;
  assign holdReqIn  = holdReq_r;
  assign extWaitSel = extWait_r;
  assign holdEnable = holdEn_r;

endmodule

// ### dv/p6cpm_chk.sv
// Purpose: APB and port-side properties of the port 6 block
// Assumes: One clock domain, async active-high reset
// Notes:   Bound to the top design module below
`timescale 1ns/10ps
module p6cpm_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        holdAckN,
  input wire logic [7:0]  pinOut,
  input wire logic [7:0]  pinOe,
  input wire logic [7:0]  pullupEn,
  input wire logic        holdEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence setupPh;
    psel && !penable;
  endsequence
  // Pin 7 path needs a settled enable first
  sequence holdOn;
    holdEnable [*3];
  endsequence
  a_reset_drv_off: assert property ($fell(rst) |-> pinOe == 8'h00)
    else $error("pin driver on after reset");
  a_pullup_input: assert property ((pullupEn & pinOe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_access_ready: assert property (setupPh |=> pready)
    else $error("no ready in access phase");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_hold: assert property (pready |=> $stable(prdata))
    else $error("read data moved after access");
  a_hold_ack: assert property (holdOn |-> pinOe[7]
    && pinOut[7] == $past(holdAckN))
    else $error("hold acknowledge not on pin");
endmodule

bind p6cpm_port6 p6cpm_chk chkI (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .holdAckN(holdAckN), .pinOut(pinOut), .pinOe(pinOe),
  .pullupEn(pullupEn), .holdEnable(holdEnable));

// ### dv/p6cpm_pins.sv
// Purpose: External devices and wiring on the eight port pins
// Assumes: Port driver wins over an external driver
// Notes:   A floating pin shows the inverse of pinOut, never a guess
`timescale 1ns/10ps
module p6cpm_pins (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupEn,
  input  wire logic [7:0] extDrv,
  input  wire logic [7:0] extVal,
  output logic      [7:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal)
    | (~pinOe & ~extDrv & pullupEn)
    | (~pinOe & ~extDrv & ~pullupEn & ~pinOut);
endmodule

// ### dv/test_port6_control_pin_mux.sv
// Purpose: Self-checking bench for the port 6 block
// Assumes: 40 MHz clock, APB master in this module
// Notes:   Pin inputs need a few edges through the synchronisers
`timescale 1ns/10ps
module test_port6_control_pin_mux;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        extAccess, readStrobeN, writeStrobeN, holdAckN, refreshReqN;
  logic        waitIn, holdReqIn, extWaitSel, holdEnable;
  logic [3:0]  upperAddr;
  logic [7:0]  pinIn, pinOut, pinOe, pullupEn, extDrv, extVal, m;
  int          numErrors, compares;
  // Rows: direction, latch, external pin levels
  logic [23:0] rows [4] = '{24'hff5ac3, 24'h00a500, 24'h0f3caa, 24'hf0817e};

  p6cpm_port6 dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upperAddr(upperAddr),
    .extAccess(extAccess), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .holdAckN(holdAckN),
    .refreshReqN(refreshReqN), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pullupEn(pullupEn), .waitIn(waitIn),
    .holdReqIn(holdReqIn), .extWaitSel(extWaitSel),
    .holdEnable(holdEnable));
  p6cpm_pins pins (.pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .extDrv(extDrv), .extVal(extVal), .pinIn(pinIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude;
    $display("errors %0d compares %0d", numErrors, compares);
    if (numErrors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // APB master: hold the request until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) numErrors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    #100us;
    numErrors++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, extAccess, upperAddr} = '0;
    {readStrobeN, writeStrobeN, extDrv, extVal} = '0;
    holdAckN = 1'b1;
    refreshReqN = 1'b1;
    rst = 1'b1;
    tick(2);
    chk(pinOe, 8'h00);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[7:0], 8'hff);
    foreach (rows[i]) begin
      m = rows[i][23:16];
      extDrv <= 8'hff;
      extVal <= rows[i][7:0];
      apb(1'b1, 12'h000, 32'(rows[i][15:8]));
      apb(1'b1, 12'h004, 32'(m));
      tick(4);
      chk(pinOe, ~m);
      chk(pinOut & ~m, rows[i][15:8] & ~m);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[7:0], (rows[i][15:8] & ~m) | (rows[i][7:0] & m));
    end
    // Latch written while all inputs, then released to the pins
    apb(1'b1, 12'h004, 32'hff);
    apb(1'b1, 12'h000, 32'h96);
    tick(3);
    chk(pinOe, 8'h00);
    apb(1'b1, 12'h004, 32'h00);
    tick(3);
    chk(pinOe, 8'hff);
    chk(pinOut, 8'h96);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(8'(err), 8'h01);
    apb(1'b1, 12'h01c, 32'h40);
    apb(1'b1, 12'h004, 32'h0f);
    tick(3);
    chk(pullupEn, 8'h0f);
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b1, 12'h004, 32'hff);
    {extAccess, upperAddr, writeStrobeN, readStrobeN} <= 7'h55;
    for (int c = 0; c < 16; c++) begin
      m = (c inside {[4:9]}) ? 8'h30 : 8'h00;
      m = m | ((c == 8) ? 8'h03 : (c == 9) ? 8'h0f : 8'h00);
      apb(1'b1, 12'h008, 32'(c));
      tick(3);
      chk(pinOe & 8'h3f, m);
      chk(pinOut & m, 8'h15 & m);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd[7:0] & 8'h3f, m);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[7:0] & m, 8'h00);
    end
    // Address pins idle low outside expanded-space accesses
    apb(1'b1, 12'h008, 32'h9);
    extAccess <= 1'b0;
    tick(3);
    chk(pinOe & 8'h0f, 8'h0f);
    chk(pinOut & 8'h0f, 8'h00);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h3);
    extVal <= 8'h00;
    tick(5);
    chk(8'(extWaitSel), 8'h01);
    chk(8'(waitIn), 8'h00);
    extVal <= 8'h40;
    tick(5);
    chk(8'(waitIn), 8'h01);
    apb(1'b1, 12'h014, 32'h1);
    holdAckN <= 1'b0;
    tick(5);
    chk(8'(holdEnable), 8'h01);
    chk(8'({pinOe[7:6], pinOut[7]}), 8'h04);
    extVal <= 8'h40;
    holdAckN <= 1'b1;
    tick(5);
    chk(8'(holdReqIn), 8'h01);
    chk(8'(waitIn), 8'h00);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h018, 32'h1);
    refreshReqN <= 1'b0;
    tick(3);
    chk(8'({pinOe[7], pinOut[7]}), 8'h02);
    refreshReqN <= 1'b1;
    tick(3);
    chk(8'({pinOe[7], pinOut[7]}), 8'h03);
    // Reset in mid-run drops every driver and restores inputs
    rst <= 1'b1;
    tick(2);
    chk(pinOe, 8'h00);
    chk(pullupEn, 8'h00);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[7:0], 8'hff);
    conclude();
  end
endmodule
